// ---- hw/wdtu_top.sv ----
// Watchdog timer unit: mode gating, clearing, time-out and cause flags
`timescale 1ns/1ps
`default_nettype none
module wdtu_top
   import wdtu_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Configuration and control
   input wire wdtu_cfg_t cfg_in,
   input wire logic prescale_wr_in,
   input wire logic sleeping_in,
   input wire wdtu_evt_t evt_in,
   // Status and actions
   output wdtu_stat_t stat_out,
   output logic [PS_W-1:0] prescale_sel_out,
   output logic active_out,
   output logic wdt_reset_out,
   output logic wake_out,
   output logic [CNT_W-1:0] count_out
);
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OST} wdtu_state_t;

   wdtu_state_t state_r;
   logic [PS_W-1:0] ps_r;
   logic [CNT_W-1:0] cnt_r;
   logic tick;
   logic enabled;
   logic clear;
   logic expire;

   // Mode table decode
   function automatic logic mode_active(input logic [1:0] mode,
                                        input logic sw_en,
                                        input logic asleep);
      case (mode)
         MODE_ON: mode_active = 1'b1;
         MODE_AWAKE: mode_active = !asleep;
         MODE_SW: mode_active = sw_en;
         default: mode_active = 1'b0;
      endcase
   endfunction

   // Period in ticks minus one
   function automatic logic [CNT_W-1:0] limit(input logic [PS_W-1:0] sel);
      logic [PS_W-1:0] s;
      s = (sel > PS_MAX) ? PS_MAX : sel;
      limit = (CNT_W'(1) << s) - CNT_W'(1);
   endfunction

   wdtu_lfosc u_lfosc (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .osc_clk_out(),
      .tick_out(tick)
   );

   // Core sleep level counts as asleep before the state machine catches up
   assign enabled = mode_active(cfg_in.watchdog_mode_cfg,
      cfg_in.sw_watchdog_enable,
      sleeping_in || state_r == ST_SLEEP);
   // Divider change is deliberately absent here
   assign clear = evt_in.clear_watchdog_instr || evt_in.sleep_enter ||
      evt_in.sleep_exit || evt_in.osc_fail || !enabled ||
      evt_in.osc_startup_timer_run || state_r == ST_OST;
   assign expire = tick && enabled && !clear &&
      cnt_r == limit(ps_r);

   // Prescale select register
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ps_r <= PS_RESET;
      end else if (wdt_reset_out) begin
         ps_r <= PS_RESET;
      end else if (prescale_wr_in) begin
         ps_r <= cfg_in.timeout_prescale_sel;
      end
   end

   // Sleep tracking
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r <= ST_RUN;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (evt_in.sleep_enter && sleeping_in) begin
                  state_r <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (evt_in.sleep_exit || expire) begin
                  state_r <= evt_in.osc_startup_timer_run ?
                     ST_OST : ST_RUN;
               end
            end
            ST_OST: begin
               if (!evt_in.osc_startup_timer_run) begin
                  state_r <= ST_RUN;
               end
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   // Watchdog count
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_r <= '0;
      end else if (clear || expire || wdt_reset_out) begin
         cnt_r <= '0;
      end else if (tick) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Time-out actions
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wdt_reset_out <= 1'b0;
         wake_out <= 1'b0;
      end else begin
         wdt_reset_out <= expire && state_r == ST_RUN;
         wake_out <= expire && state_r == ST_SLEEP;
      end
   end

   // Cause flags, set to 1 at power-on
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stat_out <= '{timeout_flag: 1'b1, powerdown_flag: 1'b1};
      end else if (expire && state_r == ST_SLEEP) begin
         stat_out <= '{timeout_flag: 1'b0, powerdown_flag: 1'b0};
      end else if (expire) begin
         stat_out.timeout_flag <= 1'b0;
      end else if (evt_in.clear_watchdog_instr) begin
         stat_out <= '{timeout_flag: 1'b1, powerdown_flag: 1'b1};
      end else if (evt_in.sleep_enter) begin
         stat_out <= '{timeout_flag: 1'b1, powerdown_flag: 1'b0};
      end
   end

   // Mirrors of internal state
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prescale_sel_out <= PS_RESET;
         active_out <= 1'b0;
         count_out <= '0;
      end else begin
         prescale_sel_out <= ps_r;
         active_out <= enabled && state_r != ST_OST;
         count_out <= cnt_r;
      end
   end
endmodule // wdtu_top
`default_nettype wire

// ---- hw/wdtu_pkg.sv ----
// Package of constants and carrier types for the watchdog timer unit
package wdtu_pkg;
   // Core clock and oscillator tick
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned LFOSC_HZ = 31_000;
   localparam int unsigned TICK_NS = 1_000_000;
   localparam int unsigned CLK_NS = 20;
   localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
   localparam int unsigned LFOSC_DIV = CLK_HZ / LFOSC_HZ;
   // Mode field encodings
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SW = 2'h1;
   localparam logic [1:0] MODE_AWAKE = 2'h2;
   localparam logic [1:0] MODE_ON = 2'h3;
   // Prescale select: period is 2**sel ms, sel 0..18
   localparam int PS_W = 5;
   localparam logic [4:0] PS_MAX = 5'h12;
   localparam logic [4:0] PS_RESET = 5'h0b;
   localparam int CNT_W = 19;
   localparam int OSC_W = 11;

   // Control inputs from the core
   typedef struct packed {
      logic [1:0] watchdog_mode_cfg;
      logic sw_watchdog_enable;
      logic [4:0] timeout_prescale_sel;
   } wdtu_cfg_t;

   // Events from core, sleep and oscillator logic
   typedef struct packed {
      logic clear_watchdog_instr;
      logic sleep_enter;
      logic sleep_exit;
      logic osc_fail;
      logic osc_startup_timer_run;
      logic divider_change;
   } wdtu_evt_t;

   // Status record of the last cause
   typedef struct packed {
      logic timeout_flag;
      logic powerdown_flag;
   } wdtu_stat_t;
endpackage

// ---- hw/wdtu_lfosc.sv ----
// Free-running low-frequency oscillator model and 1 ms tick source
`timescale 1ns/1ps
`default_nettype none
module wdtu_lfosc
   import wdtu_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Tick outputs
   output logic osc_clk_out,
   output logic tick_out
);
   logic [OSC_W-1:0] osc_cnt_r;
   logic [15:0] tick_cnt_r;

   // Independent of core divider settings
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         osc_cnt_r <= '0;
         osc_clk_out <= 1'b0;
      end else if (osc_cnt_r == OSC_W'(LFOSC_DIV / 2 - 1)) begin
         osc_cnt_r <= '0;
         osc_clk_out <= ~osc_clk_out;
      end else begin
         osc_cnt_r <= osc_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tick_cnt_r <= '0;
         tick_out <= 1'b0;
      end else if (tick_cnt_r == 16'(TICK_CYC - 1)) begin
         tick_cnt_r <= '0;
         tick_out <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
         tick_out <= 1'b0;
      end
   end
endmodule // wdtu_lfosc
`default_nettype wire

// ---- testbench/wdtu_core_model.sv ----
// Core model: sleep entry and exit around the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdtu_core_model
   import wdtu_pkg::*;
(
   // Clock, reset, requests
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic sleep_in,
   input wire logic wake_in,
   input wire wdtu_evt_t misc_in,
   // Core side
   output logic sleeping_out,
   output wdtu_evt_t evt_out
);
   logic [2:0] ost_cnt_r;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sleeping_out <= 1'b0;
         evt_out <= '0;
         ost_cnt_r <= 3'h0;
      end else begin
         evt_out <= misc_in;
         // Start-up timer keeps running a few cycles after exit
         if (ost_cnt_r != 3'h0) begin
            ost_cnt_r <= ost_cnt_r - 3'h1;
            evt_out.osc_startup_timer_run <= 1'b1;
         end
         if (sleep_in && !sleeping_out) begin
            sleeping_out <= 1'b1;
            evt_out.sleep_enter <= 1'b1;
         end
         // Crystal clock: start-up timer runs from exit
         if (wake_in && sleeping_out) begin
            sleeping_out <= 1'b0;
            evt_out.sleep_exit <= 1'b1;
            evt_out.osc_startup_timer_run <= 1'b1;
            ost_cnt_r <= 3'h4;
         end
      end
   end
endmodule // wdtu_core_model
`default_nettype wire

// ---- testbench/wdtu_properties.sv ----
// Port checker for the watchdog timer unit
`timescale 1ns/1ps
`default_nettype none
module wdtu_properties
   import wdtu_pkg::*;
(
   // Watched ports
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire wdtu_cfg_t cfg_in,
   input wire logic sleeping_in,
   input wire wdtu_evt_t evt_in,
   input wire wdtu_stat_t stat_out,
   input wire logic active_out,
   input wire logic wdt_reset_out,
   input wire logic wake_out,
   input wire logic [CNT_W-1:0] count_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   logic [1:0] md;
   assign md = cfg_in.watchdog_mode_cfg;
   sequence s_clr;
      evt_in.clear_watchdog_instr || evt_in.osc_fail || evt_in.sleep_enter;
   endsequence
   sequence s_exit_ost;
      evt_in.sleep_exit && evt_in.osc_startup_timer_run
         ##1 evt_in.osc_startup_timer_run [*2];
   endsequence
   mode_off_a: assert property (md == MODE_OFF |=> !active_out)
      else $error("active in mode off");
   asleep_off_a: assert property (
      md == MODE_AWAKE && sleeping_in |=> !active_out)
      else $error("active asleep in awake mode");
   sw_mode_a: assert property (
      md == MODE_SW |=> active_out == $past(cfg_in.sw_watchdog_enable))
      else $error("software enable ignored");
   clear_evt_a: assert property (s_clr |-> ##[1:2] count_out == 0)
      else $error("count not cleared");
   ost_hold_a: assert property (s_exit_ost |-> count_out == 0)
      else $error("count runs during start-up");
   sleep_reset_a: assert property (sleeping_in |=> !wdt_reset_out)
      else $error("reset while asleep");
   wake_flags_a: assert property (
      wake_out |-> ##[0:1] stat_out == 2'b00)
      else $error("wake flags wrong");
   reset_flag_a: assert property (
      wdt_reset_out |-> ##[0:1] !stat_out.timeout_flag)
      else $error("timeout flag not cleared");
endmodule // wdtu_properties
bind wdtu_top wdtu_properties u_props (.clk_in(clk_in),
   .arst_n_in(arst_n_in), .cfg_in(cfg_in), .sleeping_in(sleeping_in),
   .evt_in(evt_in), .stat_out(stat_out), .active_out(active_out),
   .wdt_reset_out(wdt_reset_out), .wake_out(wake_out),
   .count_out(count_out));
`default_nettype wire

// ---- testbench/test_watchdog_timer_unit.sv ----
// Bench for the watchdog timer unit
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_timer_unit;
   import wdtu_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, slp = 0, sl, act, rst, wake;
   wdtu_cfg_t cfg = '0;
   wdtu_evt_t misc = '0, evt;
   wdtu_stat_t stat;
   logic [PS_W-1:0] ps;
   logic [CNT_W-1:0] cnt;
   logic [2:0] sig;
   int n_errors = 0, n_tests = 0, t0;
   assign sig = {|cnt, wake, rst};
   wdtu_top u_dut (.clk_in(clk), .arst_n_in(rst_n), .cfg_in(cfg),
      .prescale_wr_in(wr), .sleeping_in(sl), .evt_in(evt),
      .stat_out(stat), .prescale_sel_out(ps), .active_out(act),
      .wdt_reset_out(rst), .wake_out(wake), .count_out(cnt));
   wdtu_core_model u_core (.clk_in(clk), .arst_n_in(rst_n),
      .sleep_in(slp), .wake_in(wake), .misc_in(misc),
      .sleeping_out(sl), .evt_out(evt));
   initial forever #10 clk = ~clk;
   task automatic check(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wait_for(input int k, lim);
      repeat (lim) begin
         @(posedge clk);
         #1;
         if (sig[k] === 1'b1) return;
      end
      n_errors++;
      end_sim();
   endtask
   task automatic wr_ps(input logic [4:0] v);
      @(posedge clk);
      cfg.timeout_prescale_sel <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic pulse(input wdtu_evt_t e);
      @(posedge clk);
      misc <= e;
      @(posedge clk);
      misc <= '0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   initial begin
      repeat (200000) @(posedge clk);
      n_errors++;
      end_sim();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      check(stat, 2'b11);
      check(ps, PS_RESET);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         cfg.watchdog_mode_cfg <= i[2:1];
         cfg.sw_watchdog_enable <= i[0];
         repeat (2) @(posedge clk);
         #1;
         check(act, i >= 3);
      end
      wr_ps(5'h1f);
      pulse(6'h00);
      check(ps, 5'h1f);
      wr_ps(5'h01);
      wait_for(2, 51000);
      t0 = 32'($time / 20);
      check(cnt, 1);
      pulse(6'h01);
      check(cnt, 1);
      wr_ps(5'h00);
      pulse(6'h24);
      check(cnt, 0);
      wait_for(0, 51000);
      check(32'($time / 20) - t0, TICK_CYC - 1);
      pulse(6'h00);
      check(stat, 2'b01);
      check(ps, PS_RESET);
      wr_ps(5'h00);
      @(posedge clk);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      cfg.watchdog_mode_cfg <= MODE_AWAKE;
      pulse(6'h00);
      check(act, 0);
      cfg.watchdog_mode_cfg <= MODE_ON;
      wait_for(1, 51000);
      check(rst, 0);
      @(posedge clk);
      misc.osc_startup_timer_run <= 1'b1;
      pulse(6'h02);
      check(cnt, 0);
      check(stat, 2'b00);
      end_sim();
   end
endmodule // test_watchdog_timer_unit
`default_nettype wire
